// ### rtl/eeprom_host_defines.svh
// timing counts and command codes for the parallel eeprom host controller
`ifndef EEPROM_HOST_DEFINES_SVH
`define EEPROM_HOST_DEFINES_SVH
`define CLK_PERIOD_NS 50
`define PAGE_BYTES 128
`define BYTE_WINDOW_NS 30000
`define BYTE_WINDOW_CYC (`BYTE_WINDOW_NS / `CLK_PERIOD_NS)
`define LOAD_WINDOW_NS 100000
`define LOAD_WINDOW_CYC ((`LOAD_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_AFTER_NS 10000000
`define HOLD_AFTER_CYC ((`HOLD_AFTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_MAX_NS 15000000
`define WRITE_MAX_CYC ((`WRITE_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_NS 250
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_ADDR_A 17'h05555
`define CMD_ADDR_B 17'h02aaa
`define CMD_DATA_AA 8'haa
`define CMD_DATA_55 8'h55
`define CMD_DATA_A0 8'ha0
`define CMD_DATA_80 8'h80
`define CMD_DATA_20 8'h20
`endif

// ### rtl/eeprom_host_pkg.sv
// types for the parallel eeprom host controller
package eeprom_host_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_SETUP = 8'h02,
    ST_STROBE = 8'h04,
    ST_GAP = 8'h08,
    ST_WAIT_LOAD = 8'h10,
    ST_POLL = 8'h20,
    ST_HOLD = 8'h40,
    ST_READ = 8'h80
  } host_state_t;
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_PROTECT_OFF = 2'h2
  } host_op_t;
endpackage : eeprom_host_pkg

// ### rtl/cycle_timer.sv
// down counter giving a done pulse when a loaded count expires
`timescale 1ns/1ps
module cycle_timer #(
  parameter int WIDTH = 20
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic running,
  output logic done
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic run;
    logic fin;
  } timer_state_t;
  timer_state_t st_reg;
  timer_state_t st_next;
  always_comb begin
    st_next = st_reg;
    st_next.fin = 1'b0;
    if (load) begin
      st_next.cnt = count;
      st_next.run = 1'b1;
    end else if (st_reg.run) begin
      if (st_reg.cnt <= 1) begin
        st_next.run = 1'b0;
        st_next.fin = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end
  assign running = st_reg.run;
  assign done = st_reg.fin;
endmodule : cycle_timer

// ### rtl/eeprom_host.sv
// host controller driving a parallel page-write eeprom over its pins
// Overview of operation
// - one page load carries 1 to 128 bytes before programming starts
// - next byte of the page is loaded within 30 us
// - host keeps protect-hold high throughout reads and writes
// - protect-hold stays high 10 ms after the last byte
// - protect-hold driven low during power transitions
// - protected writes are preceded by a three-byte unlock
// - six-byte sequence ending 20 to 5555 cancels protection
`timescale 1ns/1ps
`include "eeprom_host_defines.svh"
module eeprom_host
  import eeprom_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire eeprom_host_pkg::host_op_t reqOp,
  input wire logic reqUnlock,
  input wire logic [16:0] reqAddr,
  input wire logic [7:0] reqData,
  input wire logic [7:0] reqLen,
  output logic reqReady,
  output logic [7:0] loadIdx,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic doneOk,
  output logic doneTimeout,
  input wire logic powerGood,
  output logic [16:0] memAddr,
  output logic [7:0] memDataOut,
  output logic memDataOe_n,
  input wire logic [7:0] memDataIn,
  output logic chipSel_n,
  output logic writeStb_n,
  output logic outEn_n,
  output logic protectHold_n,
  input wire logic busy_n
);
  import eeprom_host_pkg::*;
  // ===========================================================
  // state
  typedef struct packed {
    host_state_t fsm;
    host_op_t op;
    logic [16:0] addr;
    logic [7:0] data;
    logic [7:0] remain;
    logic [7:0] idx;
    logic [2:0] pre;
    logic [3:0] strobeCnt;
    logic lastBit7;
    logic ready;
    logic rdV;
    logic [7:0] rdD;
    logic okP;
    logic toP;
    logic [16:0] pAddr;
    logic [7:0] pData;
    logic dOe_n;
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic hold_n;
  } host_reg_t;
  host_reg_t st_reg;
  host_reg_t st_next;
  logic tmrLoad;
  logic [18:0] tmrCount;
  logic tmrRun;
  logic tmrDone;
  // ===========================================================
  // timers
  cycle_timer #(.WIDTH(19)) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .load(tmrLoad),
    .count(tmrCount),
    .running(tmrRun),
    .done(tmrDone)
  );
  // command byte of a sequence step: six cancel steps or three unlock steps
  function automatic logic [24:0] seqByte(input host_op_t op,
                                          input logic [2:0] n);
    logic [24:0] r;
    r = {`CMD_ADDR_A, `CMD_DATA_AA};
    if (n == 3'h1 || n == 3'h4) begin
      r = {`CMD_ADDR_B, `CMD_DATA_55};
    end else if (op == OP_PROTECT_OFF && n == 3'h2) begin
      r = {`CMD_ADDR_A, `CMD_DATA_80};
    end else if (op == OP_PROTECT_OFF && n == 3'h5) begin
      r = {`CMD_ADDR_A, `CMD_DATA_20};
    end else if (op != OP_PROTECT_OFF && n == 3'h2) begin
      r = {`CMD_ADDR_A, `CMD_DATA_A0};
    end
    return r;
  endfunction : seqByte
  // ===========================================================
  // next state
  always_comb begin
    logic [24:0] sb;
    sb = '0;
    st_next = st_reg;
    st_next.rdV = 1'b0;
    st_next.okP = 1'b0;
    st_next.toP = 1'b0;
    tmrLoad = 1'b0;
    tmrCount = '0;
    st_next.hold_n = powerGood;
    unique case (st_reg.fsm)
      ST_IDLE: begin
        st_next.ready = powerGood;
        if (reqValid && st_reg.ready && powerGood) begin
          st_next.ready = 1'b0;
          st_next.op = reqOp;
          st_next.addr = reqAddr;
          st_next.data = reqData;
          st_next.remain = (reqLen == 8'h00) ? 8'h01 :
            ((reqLen > 8'h80) ? 8'h80 : reqLen);
          st_next.idx = 8'h00;
          st_next.pre = (reqOp == OP_PROTECT_OFF) ? 3'h5 :
            ((reqOp == OP_WRITE && reqUnlock) ? 3'h3 : 3'h0);
          st_next.fsm = (reqOp == OP_READ) ? ST_READ : ST_SETUP;
          st_next.strobeCnt = '0;
        end
      end
      ST_SETUP: begin
        if (st_reg.op == OP_PROTECT_OFF || st_reg.pre != 3'h0) begin
          // six cancel steps with pre 5 down to 0, or three unlock steps with pre 3 down to 1
          sb = seqByte(st_reg.op, 3'(5 - st_reg.pre));
          if (st_reg.op != OP_PROTECT_OFF) begin
            sb = seqByte(st_reg.op, 3'(3 - st_reg.pre));
          end
          st_next.pAddr = sb[24:8];
          st_next.pData = sb[7:0];
        end else begin
          // byte slot from low seven bits
          st_next.pAddr = {st_reg.addr[16:7],
            st_reg.addr[6:0] + st_reg.idx[6:0]};
          st_next.pData = st_reg.data;
        end
        st_next.dOe_n = 1'b0;
        st_next.oe_n = 1'b1;
        st_next.cs_n = 1'b0;
        st_next.fsm = ST_STROBE;
        st_next.strobeCnt = '0;
      end
      ST_STROBE: begin
        // strobe kept far above the noise width
        st_next.we_n = 1'b0;
        st_next.strobeCnt = st_reg.strobeCnt + 1'b1;
        if (st_reg.strobeCnt == 4'(`STROBE_CYC)) begin
          st_next.we_n = 1'b1;
          st_next.cs_n = 1'b1;
          st_next.fsm = ST_GAP;
        end
      end
      ST_GAP: begin
        st_next.dOe_n = 1'b1;
        st_next.lastBit7 = st_reg.pData[7];
        if (st_reg.pre != 3'h0) begin
          st_next.pre = st_reg.pre - 1'b1;
          st_next.fsm = ST_SETUP;
        end else if (st_reg.op == OP_PROTECT_OFF) begin
          st_next.fsm = ST_WAIT_LOAD;
          st_next.remain = 8'h00;
        end else begin
          st_next.remain = st_reg.remain - 1'b1;
          st_next.idx = st_reg.idx + 1'b1;
          st_next.fsm = ST_WAIT_LOAD;
        end
        st_next.data = reqData;
        st_next.ready = 1'b0;
        tmrLoad = 1'b1;
        tmrCount = 19'(`BYTE_WINDOW_CYC);
        if (st_reg.pre == 3'h0 &&
            (st_reg.remain <= 8'h01 || st_reg.op == OP_PROTECT_OFF)) begin
          // idle strobes close the load window
          tmrCount = 19'(`LOAD_WINDOW_CYC);
        end
      end
      ST_WAIT_LOAD: begin
        if (st_reg.remain != 8'h00 && st_reg.op == OP_WRITE) begin
          st_next.data = reqData;
          st_next.fsm = ST_SETUP;
        end else if (tmrDone) begin
          tmrLoad = 1'b1;
          tmrCount = 19'(`WRITE_MAX_CYC);
          st_next.oe_n = 1'b0;
          st_next.cs_n = 1'b0;
          st_next.fsm = ST_POLL;
        end
      end
      ST_POLL: begin
        // poll bit 7 or busy pin; wait
        // either is enough: ignored or cancel bytes never show up as data
        if (busy_n || memDataIn[7] == st_reg.lastBit7) begin
          st_next.oe_n = 1'b1;
          st_next.cs_n = 1'b1;
          tmrLoad = 1'b1;
          tmrCount = 19'(`HOLD_AFTER_CYC);
          st_next.fsm = ST_HOLD;
        end else if (tmrDone) begin
          st_next.oe_n = 1'b1;
          st_next.cs_n = 1'b1;
          st_next.toP = 1'b1;
          st_next.fsm = ST_IDLE;
        end
      end
      ST_HOLD: begin
        // hold protect high after last byte
        if (tmrDone || !tmrRun) begin
          st_next.okP = 1'b1;
          st_next.fsm = ST_IDLE;
        end
      end
      ST_READ: begin
        st_next.pAddr = st_reg.addr;
        st_next.cs_n = 1'b0;
        st_next.oe_n = 1'b0;
        st_next.strobeCnt = st_reg.strobeCnt + 1'b1;
        if (st_reg.strobeCnt == 4'(`STROBE_CYC)) begin
          st_next.rdV = 1'b1;
          st_next.rdD = memDataIn;
          st_next.cs_n = 1'b1;
          st_next.oe_n = 1'b1;
          st_next.fsm = ST_IDLE;
        end
      end
    endcase
    // power loss drops protect and aborts the access
    if (!powerGood && st_reg.fsm != ST_IDLE) begin
      st_next = st_reg;
      st_next.rdV = 1'b0;
      st_next.okP = 1'b0;
      st_next.toP = 1'b1;
      st_next.hold_n = 1'b0;
      st_next.cs_n = 1'b1;
      st_next.we_n = 1'b1;
      st_next.oe_n = 1'b1;
      st_next.dOe_n = 1'b1;
      st_next.ready = 1'b0;
      st_next.fsm = ST_IDLE;
    end
  end
  // ===========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.fsm <= ST_IDLE;
      st_reg.cs_n <= 1'b1;
      st_reg.we_n <= 1'b1;
      st_reg.oe_n <= 1'b1;
      st_reg.dOe_n <= 1'b1;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end
  assign reqReady = st_reg.ready;
  assign loadIdx = st_reg.idx;
  assign rdValid = st_reg.rdV;
  assign rdData = st_reg.rdD;
  assign doneOk = st_reg.okP;
  assign doneTimeout = st_reg.toP;
  assign memAddr = st_reg.pAddr;
  assign memDataOut = st_reg.pData;
  assign memDataOe_n = st_reg.dOe_n;
  assign chipSel_n = st_reg.cs_n;
  assign writeStb_n = st_reg.we_n;
  assign outEn_n = st_reg.oe_n;
  assign protectHold_n = st_reg.hold_n;
  // ===========================================================
  // checks
  // strobe width
  a_strobe_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(writeStb_n) |-> !writeStb_n [*5])
    else $error("write strobe too short");
  a_hold_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    !writeStb_n |-> protectHold_n)
    else $error("strobe while protect low");
  a_addr_steady: assert property (@(posedge core_clk) disable iff (!rst_n)
    !writeStb_n && $past(!writeStb_n) |-> $stable(memAddr))
    else $error("address moved in strobe");
  a_data_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(writeStb_n) |-> !memDataOe_n)
    else $error("data released before strobe rose");
  // cancel ends with 20 to 5555
  a_cancel_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg.fsm == ST_GAP && st_reg.op == OP_PROTECT_OFF
    && st_reg.pre == 3'h0
    |-> memAddr == `CMD_ADDR_A && memDataOut == `CMD_DATA_20)
    else $error("cancel sequence wrong last byte");
  a_unlock_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(st_reg.fsm == ST_IDLE) && st_reg.fsm == ST_SETUP && st_reg.pre != 0
    |=> memAddr == `CMD_ADDR_A && memDataOut == `CMD_DATA_AA)
    else $error("sequence does not open with aa");
  a_page_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg.fsm == ST_STROBE && st_reg.pre == 0 && st_reg.op == OP_WRITE
    |-> memAddr[16:7] == st_reg.addr[16:7])
    else $error("page crossed");
  a_page_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg.idx <= 8'h80)
    else $error("more than one page loaded");
  c_write: cover property (@(posedge core_clk) doneOk);
  c_read: cover property (@(posedge core_clk) rdValid);
  c_abort: cover property (@(posedge core_clk) doneTimeout);
endmodule : eeprom_host

// ### test/eeprom_dev_model.sv
// behavioural page-write eeprom answering the host controller
`timescale 1ns/1ps
module eeprom_dev_model #(
  parameter int progNs = 200000
) (
  input wire logic [16:0] memAddr,
  input wire logic [7:0] memDataOut,
  input wire logic chipSel_n,
  input wire logic writeStb_n,
  input wire logic outEn_n,
  input wire logic protectHold_n,
  output logic [7:0] memDataIn,
  output logic busy_n
);
  logic [7:0] mem [int];
  logic [16:0] qa [$];
  logic [7:0] qd [$];
  logic [16:0] aLat;
  logic [7:0] lastD;
  logic prot = 1'b0;
  logic busy = 1'b0;
  realtime tFall = 0.0;
  realtime tLast = 0.0;
  logic armed = 1'b0;
  // low from first byte, pulled up after
  assign busy_n = busy ? 1'b0 : 1'b1;
  always @(negedge chipSel_n or negedge writeStb_n) begin
    if (!chipSel_n && !writeStb_n && protectHold_n) begin
      aLat = memAddr;
      tFall = $realtime;
      armed = 1'b1;
    end
  end
  task automatic take();
    if (protectHold_n && $realtime - tFall > 20.0) begin
      qa.push_back(aLat);
      qd.push_back(memDataOut);
      lastD = memDataOut;
      tLast = $realtime;
      busy = 1'b1;
    end
  endtask : take
  // data at earlier rising strobe; both may rise in one step
  always @(posedge writeStb_n or posedge chipSel_n) begin
    if (armed) begin
      armed = 1'b0;
      take();
    end
  end
  function automatic logic cmd(int i, logic [14:0] a, logic [7:0] d);
    return i < qa.size() && qa[i][14:0] == a && qd[i] == d;
  endfunction : cmd
  // ====================================
  // programming
  initial forever begin
    #1000;
    // idle strobes for 100 us start programming
    if (qa.size() != 0 && $realtime - tLast >= 100000.0) begin
      int n;
      n = 0;
      if (cmd(0, 15'h5555, 8'haa) && cmd(1, 15'h2aaa, 8'h55) &&
          cmd(2, 15'h5555, 8'h80) && cmd(3, 15'h5555, 8'haa) &&
          cmd(4, 15'h2aaa, 8'h55) && cmd(5, 15'h5555, 8'h20)) begin
        prot = 1'b0;
        n = qa.size();
      end else if (cmd(0, 15'h5555, 8'haa) && cmd(1, 15'h2aaa, 8'h55) &&
                   cmd(2, 15'h5555, 8'ha0)) begin
        prot = 1'b1;
        n = 3;
      end else if (prot) begin
        n = qa.size();
      end
      repeat (progNs / 1000) if (protectHold_n) #1000;
      if (protectHold_n) for (int i = n; i < qa.size(); i++) mem[qa[i]] = qd[i];
      qa.delete();
      qd.delete();
      busy = 1'b0;
    end
  end
  // polled bit 7 inverted while busy
  always begin
    #5;
    if (!chipSel_n && !outEn_n && writeStb_n && protectHold_n)
      memDataIn = busy ? {~lastD[7], 7'h00} :
                  (mem.exists(memAddr) ? mem[memAddr] : 8'hff);
    else
      memDataIn = (memDataIn === 8'h5a) ? 8'ha5 : 8'h5a;
  end
endmodule : eeprom_dev_model

// ### test/tb.sv
// self-checking bench for the eeprom host controller
`timescale 1ns/1ps
module tb;
  import eeprom_host_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, reqValid = 1'b0;
  host_op_t reqOp = OP_WRITE;
  logic reqUnlock = 1'b0, powerGood = 1'b0, reqReady, rdValid, doneOk;
  logic [16:0] reqAddr = 17'h00000, memAddr;
  logic [7:0] reqData = 8'h00, reqLen = 8'h01, loadIdx, rdData, memDataOut;
  logic [7:0] memDataIn;
  logic doneTimeout, memDataOe_n, chipSel_n, writeStb_n, outEn_n;
  logic protectHold_n, busy_n;
  logic [31:0] seed = 32'hf44c4580;
  logic [7:0] pg [128] = '{default: 8'h00};
  logic [7:0] exp [int];
  int badCount = 0, checksDone = 0;
  eeprom_host u_eeprom_host (.core_clk, .rst_n, .clkEn, .reqValid, .reqOp,
    .reqUnlock, .reqAddr, .reqData, .reqLen, .reqReady, .loadIdx, .rdValid,
    .rdData, .doneOk, .doneTimeout, .powerGood, .memAddr, .memDataOut,
    .memDataOe_n, .memDataIn, .chipSel_n, .writeStb_n, .outEn_n,
    .protectHold_n, .busy_n);
  eeprom_dev_model u_eeprom_dev_model (.memAddr, .memDataOut, .chipSel_n,
    .writeStb_n, .outEn_n, .protectHold_n, .memDataIn, .busy_n);
  initial forever #25 core_clk = ~core_clk;
  // next page byte follows loadIdx; idle shows byte 0, idx is stale there
  always @(posedge core_clk) begin
    #2;
    reqData = pg[reqReady ? 7'h00 : loadIdx[6:0]];
  end
  // ====================================
  // helpers
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [16:0] slot(logic [16:0] a, int i);
    return {a[16:7], 7'(a[6:0] + i)};
  endfunction : slot
  function automatic logic [7:0] want(logic [16:0] a);
    return exp.exists(a) ? exp[a] : 8'hff;
  endfunction : want
  task automatic chk8(logic [7:0] got, logic [7:0] w);
    checksDone++;
    if (got !== w) begin
      badCount++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, w);
    end
  endtask : chk8
  task automatic chk1(logic got, logic w);
    checksDone++;
    if (got !== w) begin
      badCount++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, w);
    end
  endtask : chk1
  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : testDone
  task automatic req(host_op_t op, logic u, logic [16:0] a, logic [7:0] n);
    reqOp = op;
    reqUnlock = u;
    reqAddr = a;
    reqLen = n;
    reqValid = 1'b1;
    while (reqReady !== 1'b1) @(posedge core_clk) #2;
    @(posedge core_clk);
    #2;
    reqValid = 1'b0;
  endtask : req
  // hold phase is cut by a power drop to keep the run short
  task automatic finish();
    int idle;
    logic seen;
    idle = 0;
    seen = 1'b0;
    repeat (20000) begin
      @(posedge core_clk);
      #2;
      if (doneOk === 1'b1 || doneTimeout === 1'b1) begin
        seen = 1'b1;
        break;
      end
      if (busy_n === 1'b0) idle = 1;
      else if (idle > 0) idle++;
      if (idle == 100) begin
        chk1(outEn_n, 1'b1);
        powerGood = 1'b0;
      end
    end
    chk1(seen, 1'b1);
    chk1(doneTimeout, 1'b1);
    if (!powerGood) chk1(protectHold_n, 1'b0);
    powerGood = 1'b1;
  endtask : finish
  task automatic rdchk(logic [16:0] a);
    req(OP_READ, 1'b0, a, 8'h01);
    repeat (50) begin
      if (rdValid === 1'b1) break;
      @(posedge core_clk);
      #2;
    end
    chk1(rdValid, 1'b1);
    chk8(rdData, want(a));
  endtask : rdchk
  task automatic wr(logic u, logic [16:0] a, int n, logic store);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      pg[i] = seed[7:0];
      if (store) exp[slot(a, i)] = seed[7:0];
    end
    // let the byte driver pick up the new page first
    @(posedge core_clk);
    #2;
    req(OP_WRITE, u, a, 8'(n));
    finish();
    for (int i = -1; i <= n; i++) rdchk(slot(a, i));
    $display("write test at %h len %0d ended", a, n);
  endtask : wr
  // ====================================
  // sequence
  initial begin
    repeat (16) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    chk1(protectHold_n, 1'b0);
    powerGood = 1'b1;
    repeat (3) begin
      seed = lfsr(seed);
      wr(1'b0, seed[16:0], 1 + seed[2:0], 1'b1);
    end
    wr(1'b0, 17'h1007e, 4, 1'b1);
    wr(1'b0, 17'h00200, 128, 1'b1);
    wr(1'b1, 17'h12345, 3, 1'b1);
    wr(1'b0, 17'h12345, 3, 1'b0);
    wr(1'b1, 17'h12345, 2, 1'b1);
    req(OP_PROTECT_OFF, 1'b0, 17'h00000, 8'h01);
    finish();
    rdchk(17'h05555);
    rdchk(17'h02aaa);
    $display("cancel test ended");
    wr(1'b0, 17'h12345, 2, 1'b1);
    testDone();
  end
  // about one and a half times the expected run
  initial begin
    repeat (100000) @(posedge core_clk);
    badCount++;
    testDone();
  end
endmodule : tb
